// ===== bench/pad_model.sv
// Pad level model for pins 30..37
`timescale 1ns/1ps
module pad_model (
  input  wire logic [6:0] drive_i,
  input  wire logic [6:0] oe_n_i,
  input  wire logic [6:0] ext_i,
  output logic      [6:0] level_o
);
  // Driven pads follow the mux, released ones the outside party
  assign level_o = (drive_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule

// ===== bench/pins_30_to_37_function_mux_tb.sv
// Self-checking bench for the pin 30..37 function multiplexer
`timescale 1ns/1ps
`define CK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; $display("mismatch %s %h %h", n, e, g); end end
module pins_30_to_37_function_mux_tb import pinmux_pkg::*;;
  logic sys_clk_i = 0, nrst_i = 0, cpu_trace_en_i = 0, cpu_trace_4wire_i = 0, packet_trace_en_i = 0;
  logic trace_frame_out_i = 0, trace_data_out_i = 0, cpu_trace_bit2_i = 0, cpu_trace_bit3_i = 0;
  logic uart3_request_to_send_n_i = 0, ctrl4_master_out_i = 0, ctrl4_master_in_i = 0, ctrl4_twi_data_i = 0;
  logic ctrl1_master_in_i = 0, ctrl1_master_out_i = 0, ctrl1_twi_data_i = 0, ctrl1_uart_tx_i = 0;
  logic timer1_ch3_i = 0, timer2_ch1_i = 0;
  logic [1:0] ctrl3_mode_select_i = 0, ctrl4_mode_select_i = 0, ctrl1_mode_select_i = 0;
  logic [3:0] portd_high_config_i = 0;
  logic [7:0] porte_low_config_i = 0, portb_low_config_i = 0, ctrl3_uart_config_i = 0, ctrl3_spi_config_i = 0;
  logic [7:0] ctrl4_spi_config_i = 0, ctrl1_spi_config_i = 0, timer2_remap_option_i = 0;
  logic [15:0] porta_high_config_i = 0, timer1_output_enables_i = 0, timer2_output_enables_i = 0;
  logic [6:0] gpio_out_i = 0, gpio_dir_out_i = 0, pad_ext = 0, gpio_in_o, pad_i, pad_o, pad_oe_n_o;
  logic [31:0] irq_src_i = 0;
  logic [4:0] irq_c_pin_select_i = 0, irq_d_pin_select_i = 0;
  logic boot_monitor_o, ctrl3_slave_select_n_o, ctrl4_master_out_o, ctrl4_master_in_o, ctrl4_twi_data_o;
  logic ctrl1_twi_data_o, timer1_ch3_o, ext_irq_c_o, ext_irq_d_o, analog_in4_en_o, analog_in5_en_o;
  int fail_count = 0, compares = 0;
  pins_30_to_37_function_mux u_pins_30_to_37_function_mux (.*);
  pad_model u_pad_model (.drive_i(pad_o), .oe_n_i(pad_oe_n_o), .ext_i(pad_ext), .level_o(pad_i));
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  task automatic stp(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic complete_run;
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_boot;
    stp(2);
    nrst_i = 1;
    stp(2);
    `CK("boot", 1'b1, boot_monitor_o)
    `CK("idle", 8'hff, {ctrl3_slave_select_n_o, pad_oe_n_o})
    pad_ext[1] = 1;
    nrst_i = 0;
    stp(2);
    nrst_i = 1;
    stp(2);
    `CK("boot_hi", 1'b0, boot_monitor_o)
    pad_ext[1] = 0;
  endtask
  task automatic t_gpio;
    gpio_dir_out_i = 7'h7f;
    gpio_out_i = 7'h55;
    stp(2);
    `CK("ana", 4'hf, {analog_in5_en_o, analog_in4_en_o, pad_oe_n_o[1:0]})
    `CK("gpio", 10'h015, {pad_oe_n_o[6:2], pad_o[6:2]})
    stp(2);
    `CK("gin", 7'h54, gpio_in_o)
    gpio_dir_out_i = 7'h00;
  endtask
  task automatic t_trace;
    porta_high_config_i = 16'h0099;
    cpu_trace_en_i = 1;
    cpu_trace_4wire_i = 1;
    cpu_trace_bit3_i = 1;
    trace_frame_out_i = 1;
    stp(2);
    `CK("cpu", 4'h2, {pad_oe_n_o[1:0], pad_o[1:0]})
    cpu_trace_en_i = 0;
    packet_trace_en_i = 1;
    stp(2);
    `CK("pkt", 4'h1, {pad_oe_n_o[1:0], pad_o[1:0]})
    porta_high_config_i = 16'h0000;
  endtask
  task automatic t_ctrl3;
    portd_high_config_i = 4'h9;
    ctrl3_mode_select_i = 2'h1;
    ctrl3_uart_config_i = 8'h20;
    uart3_request_to_send_n_i = 1;
    stp(2);
    `CK("rts", 2'b01, {pad_oe_n_o[3], pad_o[3]})
    ctrl3_mode_select_i = 2'h2;
    ctrl3_spi_config_i = 8'h10;
    portd_high_config_i = 4'h1;
    stp(4);
    `CK("ssel", 1'b0, ctrl3_slave_select_n_o)
  endtask
  task automatic t_ctrl4;
    ctrl4_mode_select_i = 2'h2;
    porte_low_config_i = 8'h19;
    ctrl4_master_out_i = 1;
    pad_ext[5] = 1;
    stp(4);
    `CK("mosi", 3'b011, {pad_oe_n_o[4], pad_o[4], ctrl4_master_in_o})
    ctrl4_spi_config_i = 8'h10;
    porte_low_config_i = 8'h91;
    pad_ext[4] = 1;
    ctrl4_master_in_i = 1;
    stp(4);
    `CK("miso", 3'b011, {pad_oe_n_o[5], pad_o[5], ctrl4_master_out_o})
    ctrl4_mode_select_i = 2'h3;
    porte_low_config_i = 8'hd1;
    stp(2);
    `CK("sda4", 1'b0, pad_oe_n_o[5])
    stp(2);
    `CK("sda4_lo", 1'b0, ctrl4_twi_data_o)
    ctrl4_twi_data_i = 1;
    stp(4);
    `CK("sda4_in", 2'b11, {pad_oe_n_o[5], ctrl4_twi_data_o})
  endtask
  task automatic t_timer;
    porta_high_config_i = 16'h0900;
    timer1_output_enables_i = 16'h0100;
    timer1_ch3_i = 1;
    stp(4);
    `CK("t1c3", 3'b011, {pad_oe_n_o[2], pad_o[2], timer1_ch3_o})
    porta_high_config_i = 16'h0000;
    stp(4);
    `CK("cap", 1'b0, timer1_ch3_o)
  endtask
  task automatic t_b1;
    portb_low_config_i = 8'h90;
    timer2_remap_option_i = 8'h10;
    timer2_output_enables_i = 16'h0001;
    ctrl1_mode_select_i = 2'h1;
    timer2_ch1_i = 1;
    stp(2);
    `CK("t2c1", 2'b01, {pad_oe_n_o[6], pad_o[6]})
    timer2_remap_option_i = 8'h00;
    stp(2);
    `CK("tx1", 2'b00, {pad_oe_n_o[6], pad_o[6]})
    ctrl1_mode_select_i = 2'h2;
    ctrl1_master_out_i = 1;
    stp(2);
    `CK("mosi1", 2'b01, {pad_oe_n_o[6], pad_o[6]})
    ctrl1_spi_config_i = 8'h10;
    timer2_remap_option_i = 8'h10;
    timer2_output_enables_i = 16'h0000;
    stp(2);
    `CK("miso1", 2'b00, {pad_oe_n_o[6], pad_o[6]})
    ctrl1_mode_select_i = 2'h3;
    portb_low_config_i = 8'hd0;
    stp(2);
    `CK("sda1", 1'b0, pad_oe_n_o[6])
    `CK("sda1_lo", 1'b0, ctrl1_twi_data_o)
    ctrl1_twi_data_i = 1;
    pad_ext[6] = 1;
    stp(4);
    `CK("sda1_in", 2'b11, {pad_oe_n_o[6], ctrl1_twi_data_o})
  endtask
  task automatic t_irq;
    for (int k = 0; k < 30; k += 7) begin
      irq_c_pin_select_i = 5'(k);
      irq_d_pin_select_i = 5'(k + 1);
      irq_src_i = (32'h1 << k) | (32'(k & 1) << (k + 1));
      stp(3);
      `CK("irq", {1'b1, 1'(k & 1)}, {ext_irq_c_o, ext_irq_d_o})
    end
  endtask
  initial begin
    t_boot();
    t_gpio();
    t_trace();
    t_ctrl3();
    t_ctrl4();
    t_timer();
    t_b1();
    t_irq();
    complete_run();
  end
  initial begin
    #50000;
    fail_count++;
    complete_run();
  end
endmodule
bind pins_30_to_37_function_mux pins_mux_chk u_pins_mux_chk (.*);

// ===== bench/pins_mux_chk.sv
// Checker on the pin 30..37 multiplexer ports
`timescale 1ns/1ps
module pins_mux_chk (
  input wire logic        sys_clk_i, nrst_i, cpu_trace_en_i, cpu_trace_4wire_i, packet_trace_en_i,
  input wire logic        trace_data_out_i, cpu_trace_bit2_i, uart3_request_to_send_n_i, ctrl3_slave_select_n_o,
  input wire logic        ctrl4_twi_data_i, timer1_ch3_o, timer2_ch1_i, analog_in4_en_o,
  input wire logic [1:0]  ctrl3_mode_select_i, ctrl4_mode_select_i,
  input wire logic [3:0]  portd_high_config_i,
  input wire logic [7:0]  porte_low_config_i, portb_low_config_i, ctrl3_uart_config_i, ctrl3_spi_config_i,
  input wire logic [7:0]  timer2_remap_option_i,
  input wire logic [15:0] porta_high_config_i, timer2_output_enables_i,
  input wire logic [6:0]  pad_i, pad_o, pad_oe_n_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_an4; porta_high_config_i[3:0] == 4'h0 |=> analog_in4_en_o && pad_oe_n_o[0]; endproperty
  a_an4: assert property (p_an4) else $error("an4");
  property p_cpu2; porta_high_config_i[3:0] == 4'h9 && cpu_trace_en_i && cpu_trace_4wire_i
    |=> !pad_oe_n_o[0] && pad_o[0] == $past(cpu_trace_bit2_i); endproperty
  a_cpu2: assert property (p_cpu2) else $error("cpu2");
  property p_pti; porta_high_config_i[7:4] == 4'h9 && !cpu_trace_en_i && packet_trace_en_i
    |=> !pad_oe_n_o[1] && pad_o[1] == $past(trace_data_out_i); endproperty
  a_pti: assert property (p_pti) else $error("pti");
  property p_rts; portd_high_config_i == 4'h9 && ctrl3_mode_select_i == 2'h1 && ctrl3_uart_config_i[5]
    |=> !pad_oe_n_o[3] && pad_o[3] == $past(uart3_request_to_send_n_i); endproperty
  a_rts: assert property (p_rts) else $error("rts");
  property p_ssel; (ctrl3_mode_select_i == 2'h2 && ctrl3_spi_config_i[4])[*4]
    |-> ctrl3_slave_select_n_o == $past(pad_i[3], 3); endproperty
  a_ssel: assert property (p_ssel) else $error("ssel");
  property p_cap; nrst_i[*4] |-> timer1_ch3_o == $past(pad_i[2], 3); endproperty
  a_cap: assert property (p_cap) else $error("cap");
  property p_t2; portb_low_config_i[7:4] == 4'h9 && timer2_remap_option_i[4] && timer2_output_enables_i[0]
    |=> !pad_oe_n_o[6] && pad_o[6] == $past(timer2_ch1_i); endproperty
  a_t2: assert property (p_t2) else $error("t2");
  property p_twi; ctrl4_mode_select_i == 2'h3 && porte_low_config_i[7:4] == 4'hd
    |=> pad_oe_n_o[5] == $past(ctrl4_twi_data_i); endproperty
  a_twi: assert property (p_twi) else $error("twi");
  c_trc: cover property (cpu_trace_en_i && porta_high_config_i[3:0] == 4'h9);
  c_t2: cover property (timer2_remap_option_i[4] && timer2_output_enables_i[0]);
  c_twi: cover property (ctrl4_mode_select_i == 2'h3);
endmodule

// ===== rtl/pins_30_to_37_function_mux.sv
// Pin function multiplexer for package pins 30 through 37
`timescale 1ns/1ps
`include "pinmux_defs.svh"
module pins_30_to_37_function_mux
  import pinmux_pkg::*;
#(
  parameter int IRQ_SRC_W = 32
) (
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    nrst_i,
  // Pin configuration nibbles
  input  wire logic [15:0]             porta_high_config_i,
  input  wire logic [3:0]              portd_high_config_i,
  input  wire logic [7:0]              porte_low_config_i,
  input  wire logic [7:0]              portb_low_config_i,
  // GPIO data and direction, order a4 a5 a6 d4 e0 e1 b1
  input  wire logic [6:0]              gpio_out_i,
  input  wire logic [6:0]              gpio_dir_out_i,
  output logic      [6:0]              gpio_in_o,
  // Trace sources
  input  wire logic                    cpu_trace_en_i,
  input  wire logic                    cpu_trace_4wire_i,
  input  wire logic                    packet_trace_en_i,
  input  wire logic                    trace_frame_out_i,
  input  wire logic                    trace_data_out_i,
  input  wire logic                    cpu_trace_bit2_i,
  input  wire logic                    cpu_trace_bit3_i,
  // Boot strap result
  output logic                         boot_monitor_o,
  // Serial controller 3
  input  wire logic [1:0]              ctrl3_mode_select_i,
  input  wire logic [7:0]              ctrl3_uart_config_i,
  input  wire logic [7:0]              ctrl3_spi_config_i,
  input  wire logic                    uart3_request_to_send_n_i,
  output logic                         ctrl3_slave_select_n_o,
  // Serial controller 4
  input  wire logic [1:0]              ctrl4_mode_select_i,
  input  wire logic [7:0]              ctrl4_spi_config_i,
  input  wire logic                    ctrl4_master_out_i,
  input  wire logic                    ctrl4_master_in_i,
  input  wire logic                    ctrl4_twi_data_i,
  output logic                         ctrl4_master_out_o,
  output logic                         ctrl4_master_in_o,
  output logic                         ctrl4_twi_data_o,
  // Serial controller 1
  input  wire logic [1:0]              ctrl1_mode_select_i,
  input  wire logic [7:0]              ctrl1_spi_config_i,
  input  wire logic                    ctrl1_master_in_i,
  input  wire logic                    ctrl1_master_out_i,
  input  wire logic                    ctrl1_twi_data_i,
  input  wire logic                    ctrl1_uart_tx_i,
  output logic                         ctrl1_twi_data_o,
  // Timers
  input  wire logic [15:0]             timer1_output_enables_i,
  input  wire logic                    timer1_ch3_i,
  output logic                         timer1_ch3_o,
  input  wire logic [15:0]             timer2_output_enables_i,
  input  wire logic [7:0]              timer2_remap_option_i,
  input  wire logic                    timer2_ch1_i,
  // External interrupt routing
  input  wire logic [IRQ_SRC_W-1:0]    irq_src_i,
  input  wire logic [`PINSEL_W-1:0]    irq_c_pin_select_i,
  input  wire logic [`PINSEL_W-1:0]    irq_d_pin_select_i,
  output logic                         ext_irq_c_o,
  output logic                         ext_irq_d_o,
  // Pads
  input  wire logic [6:0]              pad_i,
  output logic      [6:0]              pad_o,
  output logic      [6:0]              pad_oe_n_o,
  output logic                         analog_in4_en_o,
  output logic                         analog_in5_en_o
);

  localparam int NP = `NUM_PINS;

  // Pad inputs and irq sources come from outside: two flops
  logic [NP-1:0]        pad_s1_r;
  logic [NP-1:0]        pad_s2_r;
  logic [IRQ_SRC_W-1:0] irq_s1_r;
  logic [IRQ_SRC_W-1:0] irq_s2_r;
  logic [1:0]           boot_win_r;

  pin_cfg_s   cfg   [NP];
  pad_drive_s drv   [NP];
  wire  [NP-1:0] alt_sel;
  wire  [NP-1:0] od_sel;
  wire  [NP-1:0] ana_sel;
  logic [NP-1:0] alt_val;
  logic [NP-1:0] alt_act;
  logic [NP-1:0] alt_od;

  assign cfg[0].nib = porta_high_config_i[3:0];
  assign cfg[1].nib = porta_high_config_i[7:4];
  assign cfg[2].nib = porta_high_config_i[11:8];
  assign cfg[3].nib = portd_high_config_i[3:0];
  assign cfg[4].nib = porte_low_config_i[3:0];
  assign cfg[5].nib = porte_low_config_i[7:4];
  assign cfg[6].nib = portb_low_config_i[7:4];

  // Function qualifiers
  wire pkt_trace = !cpu_trace_en_i && packet_trace_en_i;
  wire cpu_trace = cpu_trace_en_i && cpu_trace_4wire_i;
  wire sc3_uart  = ctrl3_mode_select_i == `SC_MODE_UART;
  wire sc3_spi   = ctrl3_mode_select_i == `SC_MODE_SPI;
  wire sc4_spi   = ctrl4_mode_select_i == `SC_MODE_SPI;
  wire sc4_twi   = ctrl4_mode_select_i == `SC_MODE_TWI;
  wire sc1_spi   = ctrl1_mode_select_i == `SC_MODE_SPI;
  wire sc1_twi   = ctrl1_mode_select_i == `SC_MODE_TWI;
  wire sc1_uart  = ctrl1_mode_select_i == `SC_MODE_UART;
  wire sc3_slave = ctrl3_spi_config_i[`SPI_CFG_SLAVE_BIT];
  wire sc4_slave = ctrl4_spi_config_i[`SPI_CFG_SLAVE_BIT];
  wire sc1_slave = ctrl1_spi_config_i[`SPI_CFG_SLAVE_BIT];
  wire t2c1_on   = timer2_output_enables_i[`TIM_CH1_OE_BIT];
  wire t2_remap  = timer2_remap_option_i[`TIM2_REMAP_C1_BIT];
  wire t2_owns   = t2_remap && t2c1_on;
  wire sc1_free  = !t2_owns;

  // Per-pin alternate source selection
  always_comb begin
    alt_val = '0;
    alt_act = '0;
    alt_od  = '0;
    if (cpu_trace) begin
      alt_val[0] = cpu_trace_bit2_i;
      alt_act[0] = 1'b1;
      alt_val[1] = cpu_trace_bit3_i;
      alt_act[1] = 1'b1;
    end else if (pkt_trace) begin
      alt_val[0] = trace_frame_out_i;
      alt_act[0] = 1'b1;
      alt_val[1] = trace_data_out_i;
      alt_act[1] = 1'b1;
    end
    alt_val[2] = timer1_ch3_i;
    alt_act[2] = timer1_output_enables_i[`TIM_CH3_OE_BIT];
    alt_val[3] = uart3_request_to_send_n_i;
    alt_act[3] = sc3_uart && ctrl3_uart_config_i[`UART_CFG_RTS_BIT];
    alt_val[4] = ctrl4_master_out_i;
    alt_act[4] = sc4_spi && !sc4_slave;
    if (sc4_twi) begin
      alt_val[5] = ctrl4_twi_data_i;
      alt_act[5] = od_sel[5];
      alt_od[5]  = 1'b1;
    end else begin
      alt_val[5] = ctrl4_master_in_i;
      alt_act[5] = sc4_spi && sc4_slave;
    end
    if (t2_owns) begin
      alt_val[6] = timer2_ch1_i;
      alt_act[6] = 1'b1;
    end else if (sc1_free && sc1_spi) begin
      alt_val[6] = sc1_slave ? ctrl1_master_in_i : ctrl1_master_out_i;
      alt_act[6] = 1'b1;
    end else if (sc1_free && sc1_twi) begin
      alt_val[6] = ctrl1_twi_data_i;
      alt_act[6] = od_sel[6];
      alt_od[6]  = 1'b1;
    end else if (sc1_free && sc1_uart) begin
      alt_val[6] = ctrl1_uart_tx_i;
      alt_act[6] = 1'b1;
    end
  end

  // Pad drive per pin
  for (genvar p = 0; p < NP; p++) begin : g_pin
    assign ana_sel[p] = (p < 2) && (cfg[p].nib == `CFG_MODE_ANALOG);
    assign alt_sel[p] = cfg[p].nib == `CFG_MODE_ALT_OUT;
    assign od_sel[p]  = cfg[p].nib == `CFG_MODE_ALT_OD;
    always_comb begin
      drv[p].analog = ana_sel[p];
      if (ana_sel[p]) begin
        drv[p].out  = 1'b0;
        drv[p].oe_n = 1'b1;
      end else if ((alt_sel[p] || od_sel[p]) && alt_act[p]) begin
        drv[p].out  = alt_val[p];
        drv[p].oe_n = (alt_od[p] || od_sel[p]) ? alt_val[p] : 1'b0;
      end else begin
        drv[p].out  = gpio_out_i[p];
        drv[p].oe_n = !gpio_dir_out_i[p];
      end
    end
    always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
        pad_o[p]      <= 1'b0;
        pad_oe_n_o[p] <= 1'b1;
      end else begin
        pad_o[p]      <= drv[p].out;
        pad_oe_n_o[p] <= drv[p].oe_n;
      end
    end
  end

  // Input synchronisers; no reset, so the boot strap sees the pin while reset is low
  always_ff @(posedge sys_clk_i) begin
    pad_s1_r <= pad_i;
    pad_s2_r <= pad_s1_r;
  end

  always_ff @(posedge sys_clk_i) begin
    irq_s1_r <= irq_src_i;
    irq_s2_r <= irq_s1_r;
  end

  // Input routing; idle-high inputs rest at 1 while their function is off
  wire sel_in3  = sc3_spi && sc3_slave;
  wire sel_mi4  = sc4_spi && !sc4_slave;
  wire sel_mo4  = sc4_spi && sc4_slave;
  wire irq_c_v  = (32'(irq_c_pin_select_i) < IRQ_SRC_W) ? irq_s2_r[irq_c_pin_select_i] : 1'b0;
  wire irq_d_v  = (32'(irq_d_pin_select_i) < IRQ_SRC_W) ? irq_s2_r[irq_d_pin_select_i] : 1'b0;
  wire [NP-1:0] gpio_in_nxt = pad_s2_r & ~{5'h00, ana_sel[1:0]};
  wire          ssel3_nxt   = sel_in3 ? pad_s2_r[3] : 1'b1;
  wire          mo4_nxt     = sel_mo4 ? pad_s2_r[4] : 1'b0;
  wire          mi4_nxt     = sel_mi4 ? pad_s2_r[5] : 1'b0;
  wire          twi4_nxt    = sc4_twi ? pad_s2_r[5] : 1'b1;
  wire          twi1_nxt    = (sc1_twi && sc1_free) ? pad_s2_r[6] : 1'b1;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      gpio_in_o <= '0;
    end else begin
      gpio_in_o <= gpio_in_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ctrl3_slave_select_n_o <= 1'b1;
    end else begin
      ctrl3_slave_select_n_o <= ssel3_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ctrl4_master_out_o <= 1'b0;
    end else begin
      ctrl4_master_out_o <= mo4_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ctrl4_master_in_o <= 1'b0;
    end else begin
      ctrl4_master_in_o <= mi4_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ctrl4_twi_data_o <= 1'b1;
    end else begin
      ctrl4_twi_data_o <= twi4_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ctrl1_twi_data_o <= 1'b1;
    end else begin
      ctrl1_twi_data_o <= twi1_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      timer1_ch3_o <= 1'b0;
    end else begin
      timer1_ch3_o <= pad_s2_r[2];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ext_irq_c_o <= 1'b0;
    end else begin
      ext_irq_c_o <= irq_c_v;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ext_irq_d_o <= 1'b0;
    end else begin
      ext_irq_d_o <= irq_d_v;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      analog_in4_en_o <= 1'b0;
    end else begin
      analog_in4_en_o <= ana_sel[0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      analog_in5_en_o <= 1'b0;
    end else begin
      analog_in5_en_o <= ana_sel[1];
    end
  end

  // Boot strap: captured on the first two edges after release; the last
  // capture holds the inverted pin level that was sampled while reset was low
  wire boot_open = boot_win_r != `BOOT_CAPTURE_EDGES;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      boot_win_r <= 2'h0;
    end else if (boot_open) begin
      boot_win_r <= boot_win_r + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      boot_monitor_o <= 1'b0;
    end else if (boot_open) begin
      boot_monitor_o <= !pad_s2_r[1];
    end
  end

endmodule

// ===== shared/pinmux_defs.svh
// Constants for the pin 30..37 function multiplexer
`ifndef PINMUX_DEFS_SVH
`define PINMUX_DEFS_SVH
`define CFG_MODE_ANALOG   4'h0
`define CFG_MODE_ALT_OUT  4'h9
`define CFG_MODE_ALT_OD   4'hd
`define SC_MODE_OFF       2'h0
`define SC_MODE_UART      2'h1
`define SC_MODE_SPI       2'h2
`define SC_MODE_TWI       2'h3
`define SPI_CFG_SLAVE_BIT 4
`define UART_CFG_RTS_BIT  5
`define TIM2_REMAP_C1_BIT 4
`define TIM_CH1_OE_BIT    0
`define TIM_CH3_OE_BIT    8
`define PINSEL_W          5
`define NUM_PINS          7
`define BOOT_CAPTURE_EDGES 2'h2
`endif

// ===== shared/pinmux_pkg.sv
// Types for the pin 30..37 function multiplexer
package pinmux_pkg;
  typedef struct packed {
    logic out;
    logic oe_n;
    logic analog;
  } pad_drive_s;

  typedef struct packed {
    logic [3:0] nib;
  } pin_cfg_s;
endpackage
